// >>> hw/smrp_cfg.svh
`ifndef SMRP_CFG_SVH
`define SMRP_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SMRP_CLK_HZ 40000000
`define SMRP_STRAP_MS 25
`define SMRP_SCL_HZ 100000
`define SMRP_BYTE_BITS 4'h8
// ----------------------------------------
// Target addressing and register indices
// ----------------------------------------
`define SMRP_TADDR_BASE 7'h18
`define SMRP_IDX_STRAP 8'h00
`define SMRP_IDX_ID 8'h01
`define SMRP_IDX_UNLOCK 8'h06
`define SMRP_IDX_PAGE 8'hFF
`define SMRP_UNLOCK_KEY 4'hA
`define SMRP_PAGE_RST 8'h00
`define SMRP_PG_CHSEL 0
`define SMRP_PG_CHEN 2
`define SMRP_PG_BCAST 3
// ----------------------------------------
// Controller AXI4-Lite map
// ----------------------------------------
`define SMRP_A_CMD 8'h00
`define SMRP_A_TADDR 8'h04
`define SMRP_A_STAT 8'h08
`define SMRP_CMD_IDX 8
`define SMRP_CMD_DATA 16
`define SMRP_RESP_OK 2'h0
`define SMRP_RESP_ERR 2'h2
`endif

// >>> hw/smrp_pkg.sv
package smrp_pkg;
  // Target byte engine states
  typedef enum logic [5:0] {
    TS_IDLE = 6'h01, TS_ADDR = 6'h02, TS_WIDX = 6'h04,
    TS_WDAT = 6'h08, TS_RDAT = 6'h10, TS_RACK = 6'h20
  } smrp_tst_e;
  // Controller engine states
  typedef enum logic [1:0] {HS_IDLE = 2'h1, HS_RUN = 2'h2} smrp_hst_e;
  // Kind of bus step the controller is in
  typedef enum logic [3:0] {
    K_START = 4'h1, K_TX = 4'h2, K_RX = 4'h4, K_STOP = 4'h8
  } smrp_kind_e;
endpackage

// >>> hw/smrp_if.sv
`timescale 1ns/1ps
interface smrp_if;
  logic scl_o;
  logic scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl_i;
  logic sda_i;
  // Open-drain wired-AND, lines pulled high when nobody drives low
  assign scl_i = ~(scl_oe & ~scl_o);
  assign sda_i = ~((h_sda_oe & ~h_sda_o) | (t_sda_oe & ~t_sda_o));
  modport host (input scl_i, input sda_i, output scl_o, output scl_oe,
                output h_sda_o, output h_sda_oe);
  modport target (input scl_i, input sda_i, output t_sda_o, output t_sda_oe);
endinterface

// >>> hw/smrp_target.sv
`timescale 1ns/1ps
`include "smrp_cfg.svh"
module smrp_target import smrp_pkg::*; #(
  parameter int STRAP_CYC = `SMRP_STRAP_MS * (`SMRP_CLK_HZ / 1000),
  parameter int NCH = 2,
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identity value
) (
  input wire logic aclk,
  input wire logic aresetn,
  smrp_if.target bus,
  input wire logic address_strap_high,
  input wire logic address_strap_low,
  input wire logic strap_high_driven,
  input wire logic strap_low_driven,
  output logic [6:0] target_addr,
  output logic addr_ready,
  output logic [7:0] page_select,
  output logic [NCH-1:0] cfg_wr_stb,
  output logic [7:0] cfg_wr_idx,
  output logic [7:0] cfg_wr_data
);
  localparam int CW = $clog2(STRAP_CYC + 1);
  localparam int SW = (NCH > 1) ? $clog2(NCH) : 1;

  // ----------------------------------------
  // State
  // ----------------------------------------
  smrp_tst_e st_q, st_d;
  logic [CW-1:0] cnt_q;
  logic [1:0] strap_q;
  logic [6:0] addr_q;
  logic addr_ok_q;
  logic scl_q, sda_q;
  logic [3:0] bit_q, bit_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic mack_q, mack_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] page_q;
  logic [3:0] unlock_q;
  logic [NCH-1:0][7:0] ch_rd;
  logic [NCH-1:0] stb_q;
  logic [7:0] widx_q, wdat_q;

  // Channel mask a write reaches under a given page value
  function automatic logic [NCH-1:0] ch_mask(input logic [7:0] pg);
    logic [NCH-1:0] m;
    m = '0;
    if (pg[`SMRP_PG_CHEN] && pg[`SMRP_PG_BCAST]) begin
      m = '1;
    end else if (pg[`SMRP_PG_CHEN]) begin
      m[pg[SW-1:`SMRP_PG_CHSEL]] = 1'b1;
    end
    return m;
  endfunction

  // ----------------------------------------
  // Bus event detection
  // ----------------------------------------
  wire scl = bus.scl_i;
  wire sda = bus.sda_i;
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_c = scl & scl_q & sda_q & ~sda;
  wire stop_c = scl & scl_q & ~sda_q & sda;
  wire byte_done = scl_fall & (bit_q == `SMRP_BYTE_BITS) & ~ack_q;
  wire addr_hit = addr_ok_q & (rx_q[7:1] == addr_q);

  // ----------------------------------------
  // Register routing
  // ----------------------------------------
  wire is_page = (idx_q == `SMRP_IDX_PAGE);
  wire ch_on = page_q[`SMRP_PG_CHEN];
  wire [SW-1:0] ch_sel = page_q[SW-1:`SMRP_PG_CHSEL];
  wire [3:0] obs_nib = (unlock_q == `SMRP_UNLOCK_KEY) ? {2'h0, strap_q} : 4'h0;
  wire [7:0] sh_rd = (idx_q == `SMRP_IDX_STRAP) ? {obs_nib, 4'h0} :
                     (idx_q == `SMRP_IDX_ID) ? ID_CODE :
                     (idx_q == `SMRP_IDX_UNLOCK) ? {4'h0, unlock_q} : 8'h00;
  wire [7:0] rd_byte = is_page ? page_q : (ch_on ? ch_rd[ch_sel] : sh_rd);
  wire wr_go = byte_done & (st_q == TS_WDAT);
  wire wr_page = wr_go & is_page;
  wire wr_unlock = wr_go & ~is_page & ~ch_on & (idx_q == `SMRP_IDX_UNLOCK);
  wire [NCH-1:0] wr_ch = (wr_go & ~is_page) ? ch_mask(page_q) : '0;

  // ----------------------------------------
  // Strap capture after power-up wait
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      strap_q <= 2'h0;
      addr_q <= `SMRP_TADDR_BASE;
      addr_ok_q <= 1'b0;
    end else if (!addr_ok_q) begin
      if (cnt_q == CW'(STRAP_CYC - 1)) begin
        strap_q <= {address_strap_high & strap_high_driven,
                    address_strap_low & strap_low_driven};
        addr_q <= `SMRP_TADDR_BASE + {5'h0, address_strap_high & strap_high_driven,
                                      address_strap_low & strap_low_driven};
        addr_ok_q <= 1'b1;
      end else begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end
    end
  end

  // ----------------------------------------
  // Byte engine next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    ack_d = ack_q;
    oe_d = oe_q;
    rx_d = rx_q;
    tx_d = tx_q;
    idx_d = idx_q;
    mack_d = mack_q;
    if (start_c) begin
      st_d = TS_ADDR; // Repeated start keeps the index
      bit_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = TS_IDLE;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        TS_ADDR, TS_WIDX, TS_WDAT: begin
          if (scl_rise && bit_q != `SMRP_BYTE_BITS) begin
            rx_d = {rx_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end
          if (byte_done) begin
            ack_d = 1'b1;
            oe_d = 1'b1;
            if (st_q == TS_ADDR && !addr_hit) begin
              st_d = TS_IDLE;
              ack_d = 1'b0;
              oe_d = 1'b0;
            end
            if (st_q == TS_WIDX) idx_d = rx_q;
            if (st_q == TS_WDAT) idx_d = idx_q + 8'h01;
          end else if (scl_fall && ack_q) begin
            ack_d = 1'b0;
            bit_d = 4'h0;
            oe_d = 1'b0;
            if (st_q == TS_ADDR && rx_q[0]) begin
              st_d = TS_RDAT;
              tx_d = rd_byte;
              oe_d = ~rd_byte[7];
            end else if (st_q == TS_ADDR) begin
              st_d = TS_WIDX;
            end else begin
              st_d = TS_WDAT;
            end
          end
        end
        TS_RDAT: begin
          if (scl_rise) bit_d = bit_q + 4'h1;
          if (scl_fall && bit_q == `SMRP_BYTE_BITS) begin
            oe_d = 1'b0;
            st_d = TS_RACK;
          end else if (scl_fall) begin
            tx_d = {tx_q[6:0], 1'b1};
            oe_d = ~tx_q[6];
          end
        end
        TS_RACK: begin
          if (scl_rise) begin
            mack_d = ~sda;
            if (!sda) idx_d = idx_q + 8'h01;
          end
          if (scl_fall && mack_q) begin
            st_d = TS_RDAT;
            bit_d = 4'h0;
            tx_d = rd_byte;
            oe_d = ~rd_byte[7];
          end else if (scl_fall) begin
            st_d = TS_IDLE;
          end
        end
        default: st_d = st_q;
      endcase
    end
  end

  // ----------------------------------------
  // Byte engine registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= TS_IDLE;
      {scl_q, sda_q} <= 2'h3; // Idle level, no false edge after reset
      {bit_q, ack_q, oe_q, mack_q} <= 7'h00;
      {rx_q, tx_q, idx_q} <= 24'h0;
    end else begin
      st_q <= st_d;
      {scl_q, sda_q} <= {scl, sda};
      {bit_q, ack_q, oe_q, mack_q} <= {bit_d, ack_d, oe_d, mack_d};
      {rx_q, tx_q, idx_q} <= {rx_d, tx_d, idx_d};
    end
  end

  // ----------------------------------------
  // Shared registers and write notification
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_q <= `SMRP_PAGE_RST;
      unlock_q <= 4'h0;
      stb_q <= '0;
      {widx_q, wdat_q} <= 16'h0;
    end else begin
      if (wr_page) page_q <= rx_q;
      if (wr_unlock) unlock_q <= rx_q[3:0];
      stb_q <= wr_ch;
      if (wr_go) {widx_q, wdat_q} <= {idx_q, rx_q};
    end
  end

  // ----------------------------------------
  // Channel register sets
  // ----------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [7:0] mem_q [256];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        for (int i = 0; i < 256; i++) mem_q[i] <= 8'h00;
      end else if (wr_ch[g]) begin
        mem_q[idx_q] <= rx_q;
      end
    end
    assign ch_rd[g] = mem_q[idx_q];
  end

  // Outputs
  assign bus.t_sda_o = 1'b0;
  assign bus.t_sda_oe = oe_q;
  assign target_addr = addr_q;
  assign addr_ready = addr_ok_q;
  assign page_select = page_q;
  assign cfg_wr_stb = stb_q;
  assign cfg_wr_idx = widx_q;
  assign cfg_wr_data = wdat_q;
endmodule

// >>> hw/smrp_ctrl.sv
`timescale 1ns/1ps
`include "smrp_cfg.svh"
module smrp_ctrl import smrp_pkg::*; #(
  parameter int DIV = `SMRP_CLK_HZ / (4 * `SMRP_SCL_HZ),
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  smrp_if.host bus,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int DW = $clog2(DIV + 1);
  smrp_hst_e hs_q;
  logic [DW-1:0] div_q;
  logic [2:0] step_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic nack_q, scl_oe_q, sda_oe_q;
  logic [6:0] taddr_q;
  logic rnw_q, err_q, done_q;
  logic [7:0] idx_q, dat_q, rdat_q;
  logic [AW-1:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_got_q, w_got_q, awr_q, wr_q, bv_q, arr_q, rv_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Step kind of the transfer sequence
  function automatic smrp_kind_e kind_of(input logic [2:0] s, input logic rd);
    case (s)
      3'h0: kind_of = K_START;
      3'h1, 3'h2: kind_of = K_TX;
      3'h3: kind_of = rd ? K_START : K_TX;
      3'h4: kind_of = rd ? K_TX : K_STOP;
      3'h5: kind_of = K_RX;
      default: kind_of = K_STOP;
    endcase
  endfunction

  // ----------------------------------------
  // AXI4-Lite decode
  // ----------------------------------------
  wire aw_hs = s_axi_awvalid & awr_q;
  wire w_hs = s_axi_wvalid & wr_q;
  wire aw_got_d = aw_got_q | aw_hs;
  wire w_got_d = w_got_q | w_hs;
  wire wr_do = aw_got_q & w_got_q & ~bv_q;
  wire ar_hs = s_axi_arvalid & arr_q;
  wire rv_d = ar_hs | (rv_q & ~s_axi_rready);
  wire hit_w = (awa_q == `SMRP_A_CMD) | (awa_q == `SMRP_A_TADDR) | (awa_q == `SMRP_A_STAT);
  wire hit_r = (s_axi_araddr == `SMRP_A_CMD) | (s_axi_araddr == `SMRP_A_TADDR) |
               (s_axi_araddr == `SMRP_A_STAT);
  wire busy = (hs_q == HS_RUN);
  wire go = wr_do & (awa_q == `SMRP_A_CMD) & ~busy; // Commands while busy are dropped
  wire [31:0] rd_word = (s_axi_araddr == `SMRP_A_CMD) ? {8'h00, dat_q, idx_q, 7'h00, rnw_q} :
                        (s_axi_araddr == `SMRP_A_TADDR) ? {25'h0, taddr_q} :
                        (s_axi_araddr == `SMRP_A_STAT) ?
                        {16'h0, rdat_q, 5'h00, done_q, err_q, busy} : 32'h0;
  wire tick = (div_q == DW'(DIV - 1));
  smrp_kind_e kind;
  assign kind = kind_of(step_q, rnw_q);
  wire [2:0] stop_step = rnw_q ? 3'h6 : 3'h4;
  wire [2:0] nstep = step_q + 3'h1;
  wire [7:0] next_tx = (nstep == 3'h1) ? {taddr_q, 1'b0} :
                       (nstep == 3'h2) ? idx_q :
                       (nstep == 3'h3) ? dat_q : {taddr_q, 1'b1};

  // ----------------------------------------
  // AXI4-Lite channels and registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_got_q, w_got_q, awr_q, wr_q, bv_q, arr_q, rv_q} <= 7'h00;
      awa_q <= '0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bresp_q <= `SMRP_RESP_OK;
      rresp_q <= `SMRP_RESP_OK;
      rdata_q <= 32'h0;
      taddr_q <= `SMRP_TADDR_BASE;
    end else begin
      if (aw_hs) awa_q <= s_axi_awaddr;
      if (w_hs) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      aw_got_q <= aw_got_d & ~wr_do;
      w_got_q <= w_got_d & ~wr_do;
      awr_q <= ~aw_got_d | wr_do;
      wr_q <= ~w_got_d | wr_do;
      if (wr_do) begin
        bv_q <= 1'b1;
        bresp_q <= hit_w ? `SMRP_RESP_OK : `SMRP_RESP_ERR;
        if (awa_q == `SMRP_A_TADDR && ws_q[0]) taddr_q <= wd_q[6:0];
      end else if (s_axi_bready) begin
        bv_q <= 1'b0;
      end
      rv_q <= rv_d;
      arr_q <= ~rv_d;
      if (ar_hs) begin
        rdata_q <= hit_r ? rd_word : 32'h0;
        rresp_q <= hit_r ? `SMRP_RESP_OK : `SMRP_RESP_ERR;
      end
    end
  end

  // ----------------------------------------
  // Bus engine: four phases per bit
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_q <= HS_IDLE;
      {div_q, step_q, ph_q, bit_q} <= '0;
      {sh_q, idx_q, dat_q, rdat_q} <= 32'h0;
      {nack_q, scl_oe_q, sda_oe_q, rnw_q, err_q, done_q} <= 6'h00;
    end else if (go) begin
      hs_q <= HS_RUN;
      {div_q, step_q, ph_q, bit_q} <= '0;
      rnw_q <= wd_q[0];
      idx_q <= wd_q[`SMRP_CMD_IDX +: 8];
      dat_q <= wd_q[`SMRP_CMD_DATA +: 8];
      {err_q, done_q} <= 2'h0;
    end else if (busy) begin
      div_q <= tick ? '0 : DW'(div_q + 1'b1);
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (kind)
          K_START: begin
            if (ph_q == 2'h0) sda_oe_q <= 1'b0;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) sda_oe_q <= 1'b1;
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              step_q <= nstep;
              sh_q <= next_tx;
            end
          end
          K_TX, K_RX: begin
            if (ph_q == 2'h0) sda_oe_q <= (kind == K_TX) & (bit_q != `SMRP_BYTE_BITS) & ~sh_q[7];
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2 && bit_q == `SMRP_BYTE_BITS) nack_q <= bus.sda_i;
            if (ph_q == 2'h2 && bit_q != `SMRP_BYTE_BITS && kind == K_RX)
              sh_q <= {sh_q[6:0], bus.sda_i};
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              if (bit_q != `SMRP_BYTE_BITS) begin
                bit_q <= bit_q + 4'h1;
                if (kind == K_TX) sh_q <= {sh_q[6:0], 1'b0};
              end else begin
                bit_q <= 4'h0;
                if (kind == K_TX && nack_q) begin
                  err_q <= 1'b1;
                  step_q <= stop_step;
                end else begin
                  step_q <= nstep;
                  sh_q <= next_tx;
                  if (kind == K_RX) rdat_q <= sh_q; // NACK ends the read
                end
              end
            end
          end
          default: begin
            if (ph_q == 2'h0) sda_oe_q <= 1'b1;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) sda_oe_q <= 1'b0;
            if (ph_q == 2'h3) begin
              hs_q <= HS_IDLE;
              done_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Outputs
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_q;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe = sda_oe_q;
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// >>> tb/smrp_checker.sv
`timescale 1ns/1ps
module smrp_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Data falls while clock high
  sequence start_s;
    scl_i && sda_i ##1 scl_i && !sda_i;
  endsequence
  // Data rises while clock high
  sequence stop_s;
    scl_i && !sda_i ##1 scl_i && sda_i;
  endsequence
  // ----------------------------------------
  // Line checks
  // ----------------------------------------
  reset_idle_a: assert property ($rose(aresetn) |-> !scl_oe && !h_sda_oe && !t_sda_oe)
    else $error("line driven right after reset");
  open_drain_a: assert property (scl_oe || h_sda_oe || t_sda_oe |-> !scl_o && !h_sda_o && !t_sda_o)
    else $error("line driven high");
  tgt_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(t_sda_oe))
    else $error("target data changed while clock high");
  tgt_launch_a: assert property ($rose(t_sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("target drove data too early");
  start_owner_a: assert property (start_s |-> h_sda_oe && !t_sda_oe)
    else $error("start not made by host");
  stop_release_a: assert property (stop_s |=> !t_sda_oe [*2])
    else $error("target drives after stop");
  scl_high_a: assert property ($rose(scl_i) |-> scl_i [*4])
    else $error("clock high phase too short");
  scl_low_a: assert property ($fell(scl_i) |-> !scl_i [*4])
    else $error("clock low phase too short");
endmodule

// >>> tb/tb_smbus_target_register_paging.sv
`timescale 1ns/1ps
module tb_smbus_target_register_paging;
  localparam int STRAP_N = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] strap = 4'h0; // Driven high, driven low, high, low
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [6:0] target_addr;
  logic addr_ready;
  logic [7:0] page_select, cfg_wr_idx, cfg_wr_data;
  logic [1:0] cfg_wr_stb;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [17:0] sq[$];
  logic [65:0] re;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #12.5 aclk = ~aclk;

  // ----------------------------------------
  // Design under test
  // ----------------------------------------
  smrp_if i_smrp_if ();
  smrp_ctrl #(.DIV(4)) i_smrp_ctrl (.aclk(aclk), .aresetn(aresetn), .bus(i_smrp_if),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  smrp_target #(.STRAP_CYC(STRAP_N)) i_smrp_target (.aclk(aclk), .aresetn(aresetn),
    .bus(i_smrp_if), .address_strap_high(strap[1]), .address_strap_low(strap[0]),
    .strap_high_driven(strap[3]), .strap_low_driven(strap[2]), .target_addr(target_addr),
    .addr_ready(addr_ready), .page_select(page_select), .cfg_wr_stb(cfg_wr_stb),
    .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data));
  smrp_checker i_smrp_checker (.aclk(aclk), .aresetn(aresetn), .scl_o(i_smrp_if.scl_o),
    .scl_oe(i_smrp_if.scl_oe), .h_sda_o(i_smrp_if.h_sda_o), .h_sda_oe(i_smrp_if.h_sda_oe),
    .t_sda_o(i_smrp_if.t_sda_o), .t_sda_oe(i_smrp_if.t_sda_oe), .scl_i(i_smrp_if.scl_i),
    .sda_i(i_smrp_if.sda_i));

  // ----------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw;
    logic w;
    bq.push_back(r);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                    input logic [1:0] r, output logic [31:0] d);
    rq.push_back({r, m, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Issue one link transfer, wait for idle, then note the expected status
  task automatic smb(input logic rnw, input logic [7:0] idx, input logic [7:0] d,
                     input logic [15:0] m, input logic [15:0] v);
    logic [31:0] s;
    axw(8'h00, {8'h00, d, idx, 7'h00, rnw}, 2'h0);
    s = 32'h1;
    while (s[0] !== 1'b0) rd(8'h08, 32'h0, 32'h0, 2'h0, s);
    rd(8'h08, {16'h0, m}, {16'h0, v}, 2'h0, s);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    smb(1'b0, idx, d, 16'h0003, 16'h0000);
  endtask
  task automatic rb(input logic [7:0] idx, input logic [7:0] e);
    smb(1'b1, idx, 8'h00, 16'hFF03, {e, 8'h00});
  endtask

  // ----------------------------------------
  // Result monitors and timeout
  // ----------------------------------------
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid === 1'b1 && s_axi_rready) begin
      re = rq.pop_front();
      chk(s_axi_rdata & re[63:32], re[31:0]);
      chk({30'h0, s_axi_rresp}, {30'h0, re[65:64]});
    end
    if (aresetn && s_axi_bvalid === 1'b1 && s_axi_bready) begin
      chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    end
    if (aresetn && cfg_wr_stb !== 2'b00) begin
      chk({14'h0, cfg_wr_stb, cfg_wr_idx, cfg_wr_data}, {14'h0, sq.pop_front()});
    end
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] cfg [5];
    logic [1:0] st;
    logic [6:0] ta;
    logic [7:0] pg, da, db, dx;
    logic [31:0] s;
    cfg = '{4'h7, 4'hC, 4'hD, 4'hB, 4'hF};
    void'($urandom(96939));
    // Each strap setting, floating lines included
    for (int i = 0; i < 5; i++) begin
      st = {cfg[i][3] & cfg[i][1], cfg[i][2] & cfg[i][0]};
      ta = 7'h18 + {5'h00, st};
      aresetn <= 1'b0;
      strap <= cfg[i];
      repeat (3) @(posedge aclk);
      chk({25'h0, target_addr}, 32'h18);
      chk({31'h0, addr_ready}, 32'h0);
      aresetn <= 1'b1;
      repeat (STRAP_N - 3) @(posedge aclk);
      chk({31'h0, addr_ready}, 32'h0);
      repeat (8) @(posedge aclk);
      chk({31'h0, addr_ready}, 32'h1);
      chk({25'h0, target_addr}, {25'h0, ta});
      strap <= ~cfg[i];
      axw(8'h04, {25'h0, ta}, 2'h0);
      pg = 8'($urandom) & 8'hFB;
      wr(8'hFF, pg);
      chk({24'h0, page_select}, {24'h0, pg});
      rb(8'hFF, pg);
      axw(8'h04, {25'h0, ta ^ 7'h01}, 2'h0);
      smb(1'b0, 8'hFF, 8'h00, 16'h0003, 16'h0002);
      chk({24'h0, page_select}, {24'h0, pg});
    end
    // Strap observation field, last strap value is 3
    axw(8'h04, {25'h0, ta}, 2'h0);
    rb(8'h00, 8'h00);
    wr(8'h06, 8'h0A);
    rb(8'h00, 8'h30);
    wr(8'h00, 8'hC5);
    rb(8'h00, 8'h30);
    // Channel paging and broadcast
    da = 8'($urandom);
    db = 8'($urandom);
    dx = 8'($urandom);
    wr(8'hFF, 8'h04);
    sq.push_back({2'b01, 8'h00, da});
    wr(8'h00, da);
    rb(8'h00, da);
    rb(8'hFF, 8'h04);
    wr(8'hFF, 8'h05);
    sq.push_back({2'b10, 8'h00, db});
    wr(8'h00, db);
    rb(8'h00, db);
    wr(8'hFF, 8'h0C);
    sq.push_back({2'b11, 8'h10, dx});
    wr(8'h10, dx);
    rb(8'h10, dx);
    wr(8'hFF, 8'h05);
    rb(8'h10, dx);
    rb(8'h00, db);
    wr(8'hFF, 8'h04);
    rb(8'h00, da);
    wr(8'hFF, 8'h00);
    rb(8'h00, 8'h30);
    // Controller map edges
    rd(8'h0C, 32'hFFFFFFFF, 32'h0, 2'h2, s);
    axw(8'h10, 32'h0, 2'h2);
    axw(8'h08, 32'h0, 2'h0);
    rd(8'h04, 32'h7F, {25'h0, ta}, 2'h0, s);
    finish_test();
  end
endmodule
